// File: hw/tslv_map.svh
// register map, field positions and reset values of the timer slave mode controller
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef TSLV_MAP_SVH
`define TSLV_MAP_SVH

`define TSLV_ADDR_W      6
`define TSLV_SMCR_OFS    6'h08
`define TSLV_STAT_OFS    6'h20
`define TSLV_SMCR_RST    16'h0000
`define TSLV_SMCR_WMASK  16'hfff7

`define TSLV_ETP_BIT     15
`define TSLV_ECE_BIT     14
`define TSLV_EXT_TRIG_PRESCALE_LSB    12
`define TSLV_ETF_LSB     8
`define TSLV_MSM_BIT     7
`define TSLV_TS_LSB      4
`define TSLV_SMS_LSB     0

`define TSLV_ST_TRIGGER_INPUT     0
`define TSLV_ST_FILTERED_EXTERNAL_TRIGGER     1
`define TSLV_ST_PRESCALED_EXTERNAL_TRIGGER     2
`define TSLV_ST_DOWN     3
`define TSLV_ST_RUN      4

`define TSLV_PSC_W       3
`define TSLV_FLT_CNT_W   3
`define TSLV_DTS_DIV_W   5

`endif

// File: hw/tslv_pkg.sv
// types of the timer slave mode controller
// used by every design file of the block
package tslv_pkg;

  typedef enum logic [2:0] {
    TSLV_SM_INT    = 3'b000,
    TSLV_SM_ENC1   = 3'b001,
    TSLV_SM_ENC2   = 3'b010,
    TSLV_SM_ENC3   = 3'b011,
    TSLV_SM_RESET  = 3'b100,
    TSLV_SM_GATED  = 3'b101,
    TSLV_SM_TRIG   = 3'b110,
    TSLV_SM_EXT1   = 3'b111
  } tslv_mode_e;

  typedef enum logic [2:0] {
    TSLV_TS_INTERNAL_TRIGGER_0   = 3'b000,
    TSLV_TS_INTERNAL_TRIGGER_1   = 3'b001,
    TSLV_TS_INTERNAL_TRIGGER_2   = 3'b010,
    TSLV_TS_INTERNAL_TRIGGER_3   = 3'b011,
    TSLV_TS_TI1ED  = 3'b100,
    TSLV_TS_FI1    = 3'b101,
    TSLV_TS_FI2    = 3'b110,
    TSLV_TS_FILTERED_EXTERNAL_TRIGGER   = 3'b111
  } tslv_src_e;

endpackage

// File: hw/tslv_etr_prescaler.sv
// edge-counting prescaler for the external trigger
// assumes the input is already synchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
`include "tslv_map.svh"
module tslv_etr_prescaler
  import tslv_pkg::*;
(
  input  wire logic       core_clk_in,  // core clock
  input  wire logic       sys_rst_in,   // async reset, high
  input  wire logic       sig_in,       // polarity-adjusted trigger
  input  wire logic [1:0] div_sel_in,   // 00 /1, 01 /2, 10 /4, 11 /8
  output logic            sig_out       // prescaled trigger
);

  logic                    prev_q, prev_d;
  logic [`TSLV_PSC_W-1:0]  cnt_q, cnt_d;

  // each rising edge advances the counter, bit k toggles at /2^(k+1)
  always_comb begin
    prev_d = sig_in;
    cnt_d  = cnt_q;
    if (sig_in && !prev_q) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
    end
  end

  always_comb begin
    if (div_sel_in == 2'b00) begin
      sig_out = sig_in;
    end else begin
      sig_out = cnt_q[div_sel_in - 2'd1];
    end
  end

endmodule // tslv_etr_prescaler
`default_nettype wire

// File: hw/tslv_etr_filter.sv
// sample-count digital filter for the prescaled external trigger
// assumes dts_tick_in is a one-cycle enable at the dead-time rate
`timescale 1ns/1ps
`default_nettype none
`include "tslv_map.svh"
module tslv_etr_filter
  import tslv_pkg::*;
(
  input  wire logic       core_clk_in,  // core clock
  input  wire logic       sys_rst_in,   // async reset, high
  input  wire logic       dts_tick_in,  // dead-time clock enable
  input  wire logic       sig_in,       // prescaled trigger
  input  wire logic [3:0] code_in,      // filter setting
  output logic            sig_out       // filtered trigger
);

  // samples of agreement needed, minus one
  function automatic logic [2:0] need_m1(input logic [3:0] c);
    case (c)
      4'h0:                      need_m1 = 3'd0;
      4'h1:                      need_m1 = 3'd1;
      4'h2:                      need_m1 = 3'd3;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: need_m1 = 3'd5;
      4'ha, 4'hd:                need_m1 = 3'd4;
      default:                   need_m1 = 3'd7;
    endcase
  endfunction

  // dead-time divider mask, all zero means every dts tick
  function automatic logic [4:0] div_mask(input logic [3:0] c);
    case (c)
      4'h4, 4'h5:       div_mask = 5'h01;
      4'h6, 4'h7:       div_mask = 5'h03;
      4'h8, 4'h9:       div_mask = 5'h07;
      4'ha, 4'hb, 4'hc: div_mask = 5'h0f;
      4'hd, 4'he, 4'hf: div_mask = 5'h1f;
      default:          div_mask = 5'h00;
    endcase
  endfunction

  logic [`TSLV_DTS_DIV_W-1:0] div_q, div_d;
  logic [`TSLV_FLT_CNT_W-1:0] cnt_q, cnt_d;
  logic                       out_q, out_d;
  logic                       smp;

  always_comb begin
    div_d = dts_tick_in ? div_q + 1'b1 : div_q;
    if (code_in inside {4'h1, 4'h2, 4'h3}) begin
      smp = 1'b1;  // internal counter clock rate
    end else begin
      smp = dts_tick_in && ((div_q & div_mask(code_in)) == '0);
    end
    cnt_d = cnt_q;
    out_d = out_q;
    if (smp) begin
      if (sig_in == out_q) begin
        cnt_d = '0;
      end else if (cnt_q == need_m1(code_in)) begin
        cnt_d = '0;
        out_d = sig_in;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_q <= '0;
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign sig_out = out_q;

endmodule // tslv_etr_filter
`default_nettype wire

// File: hw/tslv_slave_ctrl.sv
// slave mode controller of a general-purpose timer, avalon-mm register slave
// assumes all pins synchronous to core_clk_in; counter and channels sit outside
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tslv_map.svh"
module tslv_slave_ctrl
  import tslv_pkg::*;
(
  input  wire logic                    core_clk_in,                   // 10 MHz core clock
  input  wire logic                    sys_rst_in,                    // async reset, high

  input  wire logic [`TSLV_ADDR_W-1:0] avs_address_in,                // byte address
  input  wire logic                    avs_read_in,                   // read request
  input  wire logic                    avs_write_in,                  // write request
  input  wire logic [31:0]             avs_writedata_in,              // write data
  input  wire logic [3:0]              avs_byteenable_in,             // byte lanes
  output logic      [31:0]             avs_readdata_out,              // read data
  output logic                         avs_waitrequest_out,           // stall

  input  wire logic                    dts_tick_in,                   // dead-time clock enable
  input  wire logic                    external_trigger_pin_in,       // external trigger pin
  input  wire logic [3:0]              internal_trigger_in,           // internal triggers 0-3
  input  wire logic                    input1_edge_detect_in,         // input 1 edge detector
  input  wire logic                    filtered_input_1_in,           // filtered input 1
  input  wire logic                    filtered_input_2_in,           // filtered input 2
  input  wire logic                    counter_enable_in,             // counter enable bit

  output logic                         count_tick_out,                // counter advance pulse
  output logic                         count_down_out,                // encoder direction
  output logic                         counter_reinit_out,            // reinit and update pulse
  output logic                         counter_start_out,             // trigger mode start pulse
  output logic                         trigger_input_out,             // selected trigger input
  output logic                         filtered_external_trigger_out  // filtered trigger
);

  // ---- register file and bus handshake
  logic [15:0] smcr_q, smcr_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [4:0]  stat;
  logic        req;
  logic        hit_smcr;
  logic        hit_stat;
  logic [15:0] lane_mask;

  logic        ext_trig_polarity;
  logic        ece;
  logic [1:0]  ext_trig_prescale;
  logic [3:0]  ext_trig_filter;
  logic        sync_delay_select;
  tslv_src_e   ts;
  tslv_mode_e  slave_mode_select;

  assign ext_trig_polarity  = smcr_q[`TSLV_ETP_BIT];
  assign ece  = smcr_q[`TSLV_ECE_BIT];
  assign ext_trig_prescale = smcr_q[`TSLV_EXT_TRIG_PRESCALE_LSB +: 2];
  assign ext_trig_filter  = smcr_q[`TSLV_ETF_LSB +: 4];
  assign sync_delay_select  = smcr_q[`TSLV_MSM_BIT];
  assign ts   = tslv_src_e'(smcr_q[`TSLV_TS_LSB +: 3]);
  assign slave_mode_select  = tslv_mode_e'(smcr_q[`TSLV_SMS_LSB +: 3]);

  assign req       = avs_read_in || avs_write_in;
  assign hit_smcr  = (avs_address_in == `TSLV_SMCR_OFS);
  assign hit_stat  = (avs_address_in == `TSLV_STAT_OFS);
  assign lane_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // one wait cycle on every access, answer at the second edge
  assign avs_waitrequest_out = req && !ack_q;

  always_comb begin
    ack_d   = req && !ack_q;
    rdata_d = rdata_q;
    smcr_d  = smcr_q;
    if (avs_read_in && !ack_q) begin
      if (hit_smcr) begin
        rdata_d = {16'h0000, smcr_q};
      end else if (hit_stat) begin
        rdata_d = {27'h0000000, stat};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    if (avs_write_in && ack_q && hit_smcr) begin
      smcr_d = (smcr_q & ~(lane_mask & `TSLV_SMCR_WMASK))
             | (avs_writedata_in[15:0] & lane_mask & `TSLV_SMCR_WMASK);
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      smcr_q  <= `TSLV_SMCR_RST;
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      smcr_q  <= smcr_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_out = rdata_q;

  // ---- external trigger conditioning
  logic etr_pol;
  logic prescaled_external_trigger;
  logic filtered_external_trigger;

  assign etr_pol = external_trigger_pin_in ^ ext_trig_polarity;

  tslv_etr_prescaler u_psc (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .sig_in      (etr_pol),
    .div_sel_in  (ext_trig_prescale),
    .sig_out     (prescaled_external_trigger)
  );

  tslv_etr_filter u_flt (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .dts_tick_in (dts_tick_in),
    .sig_in      (prescaled_external_trigger),
    .code_in     (ext_trig_filter),
    .sig_out     (filtered_external_trigger)
  );

  assign filtered_external_trigger_out = filtered_external_trigger;

  // ---- trigger input selection
  logic trigger_input;

  always_comb begin
    unique case (ts)
      TSLV_TS_INTERNAL_TRIGGER_0:  trigger_input = internal_trigger_in[0];
      TSLV_TS_INTERNAL_TRIGGER_1:  trigger_input = internal_trigger_in[1];
      TSLV_TS_INTERNAL_TRIGGER_2:  trigger_input = internal_trigger_in[2];
      TSLV_TS_INTERNAL_TRIGGER_3:  trigger_input = internal_trigger_in[3];
      TSLV_TS_TI1ED: trigger_input = input1_edge_detect_in;
      TSLV_TS_FI1:   trigger_input = filtered_input_1_in;
      TSLV_TS_FI2:   trigger_input = filtered_input_2_in;
      TSLV_TS_FILTERED_EXTERNAL_TRIGGER:  trigger_input = filtered_external_trigger;
    endcase
  end

  assign trigger_input_out = trigger_input;

  // ---- history of trigger and inputs
  logic trg_q, trg_d;
  logic dly_q, dly_d;
  logic eff_prev_q, eff_prev_d;
  logic filtered_external_trigger_prev_q, filtered_external_trigger_prev_d;
  logic fi1_prev_q, fi1_prev_d;
  logic fi2_prev_q, fi2_prev_d;
  logic trg_eff;

  // extra stage lets the trigger output of this timer lead its slaves
  assign trg_eff = sync_delay_select ? dly_q : trg_q;

  always_comb begin
    trg_d       = trigger_input;
    dly_d       = trg_q;
    eff_prev_d  = trg_eff;
    filtered_external_trigger_prev_d = filtered_external_trigger;
    fi1_prev_d  = filtered_input_1_in;
    fi2_prev_d  = filtered_input_2_in;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trg_q       <= 1'b0;
      dly_q       <= 1'b0;
      eff_prev_q  <= 1'b0;
      filtered_external_trigger_prev_q <= 1'b0;
      fi1_prev_q  <= 1'b0;
      fi2_prev_q  <= 1'b0;
    end else begin
      trg_q       <= trg_d;
      dly_q       <= dly_d;
      eff_prev_q  <= eff_prev_d;
      filtered_external_trigger_prev_q <= filtered_external_trigger_prev_d;
      fi1_prev_q  <= fi1_prev_d;
      fi2_prev_q  <= fi2_prev_d;
    end
  end

  // ---- edges
  logic trg_rise;
  logic filtered_external_trigger_rise;
  logic fi1_edge;
  logic fi1_rise;
  logic fi2_edge;
  logic fi2_rise;
  logic fi1_lvl;
  logic fi2_lvl;

  assign trg_rise  = trg_eff && !eff_prev_q;
  assign filtered_external_trigger_rise = filtered_external_trigger && !filtered_external_trigger_prev_q;
  assign fi1_lvl   = filtered_input_1_in;
  assign fi2_lvl   = filtered_input_2_in;
  assign fi1_edge  = fi1_lvl ^ fi1_prev_q;
  assign fi1_rise  = fi1_lvl && !fi1_prev_q;
  assign fi2_edge  = fi2_lvl ^ fi2_prev_q;
  assign fi2_rise  = fi2_lvl && !fi2_prev_q;

  // ---- mode decision
  logic tick_q, tick_d;
  logic down_q, down_d;
  logic reinit_q, reinit_d;
  logic start_q, start_d;
  logic run;

  always_comb begin
    tick_d   = 1'b0;
    down_d   = down_q;
    reinit_d = 1'b0;
    start_d  = 1'b0;
    run      = counter_enable_in;

    unique case (slave_mode_select)
      TSLV_SM_INT: begin
        tick_d = counter_enable_in;
      end
      TSLV_SM_ENC1: begin
        tick_d = counter_enable_in && fi2_edge;
        if (fi2_edge) begin
          down_d = (fi2_rise != fi1_lvl);
        end
      end
      TSLV_SM_ENC2: begin
        tick_d = counter_enable_in && fi1_edge;
        if (fi1_edge) begin
          down_d = (fi1_rise == fi2_lvl);
        end
      end
      TSLV_SM_ENC3: begin
        tick_d = counter_enable_in && (fi1_edge || fi2_edge);
        if (fi1_edge) begin
          down_d = (fi1_rise == fi2_lvl);
        end else if (fi2_edge) begin
          down_d = (fi2_rise != fi1_lvl);
        end
      end
      TSLV_SM_RESET: begin
        tick_d   = counter_enable_in;
        reinit_d = trg_rise;
      end
      TSLV_SM_GATED: begin
        run    = counter_enable_in && trg_eff;
        tick_d = run;
      end
      TSLV_SM_TRIG: begin
        start_d = trg_rise;
        run     = counter_enable_in || trg_rise;
        tick_d  = run;
      end
      TSLV_SM_EXT1: begin
        tick_d = counter_enable_in && trg_rise;
      end
    endcase

    // external clock mode 2 replaces the clock, keeps reset/gate/start
    if (ece) begin
      tick_d = run && filtered_external_trigger_rise;
      if (slave_mode_select == TSLV_SM_EXT1) begin
        tick_d = counter_enable_in && filtered_external_trigger_rise;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tick_q   <= 1'b0;
      down_q   <= 1'b0;
      reinit_q <= 1'b0;
      start_q  <= 1'b0;
    end else begin
      tick_q   <= tick_d;
      down_q   <= down_d;
      reinit_q <= reinit_d;
      start_q  <= start_d;
    end
  end

  assign count_tick_out     = tick_q;
  assign count_down_out     = down_q;
  assign counter_reinit_out = reinit_q;
  assign counter_start_out  = start_q;

  // ---- status word
  always_comb begin
    stat                = 5'h00;
    stat[`TSLV_ST_TRIGGER_INPUT] = trg_eff;
    stat[`TSLV_ST_FILTERED_EXTERNAL_TRIGGER] = filtered_external_trigger;
    stat[`TSLV_ST_PRESCALED_EXTERNAL_TRIGGER] = prescaled_external_trigger;
    stat[`TSLV_ST_DOWN] = down_q;
    stat[`TSLV_ST_RUN]  = run;
  end

endmodule // tslv_slave_ctrl
`default_nettype wire

// File: verif/tslv_slave_ctrl_assertions.sv
// checker of the slave mode controller ports
// assumes one clock domain and the control register at the map offset
`timescale 1ns/1ps
`default_nettype none
`include "tslv_map.svh"
module tslv_slave_ctrl_assertions
  import tslv_pkg::*;
(
  input wire logic                    core_clk_in,                  // core clock
  input wire logic                    sys_rst_in,                   // async reset
  input wire logic [`TSLV_ADDR_W-1:0] avs_address_in,               // address
  input wire logic                    avs_read_in,                  // read
  input wire logic                    avs_write_in,                 // write
  input wire logic [31:0]             avs_writedata_in,             // write data
  input wire logic [3:0]              avs_byteenable_in,            // lanes
  input wire logic                    avs_waitrequest_out,          // stall
  input wire logic                    counter_enable_in,            // enable
  input wire logic [3:0]              internal_trigger_in,          // triggers
  input wire logic                    input1_edge_detect_in,        // edge det
  input wire logic                    filtered_input_1_in,          // input 1
  input wire logic                    filtered_input_2_in,          // input 2
  input wire logic                    count_tick_out,               // tick
  input wire logic                    count_down_out,               // direction
  input wire logic                    counter_reinit_out,           // reinit
  input wire logic                    counter_start_out,            // start
  input wire logic                    trigger_input_out,            // trigger
  input wire logic                    filtered_external_trigger_out // filtered
);
  logic [15:0] cfg_q;
  logic [7:0]  srcs;
  logic [2:0]  slave_mode_select;
  assign slave_mode_select  = cfg_q[2:0];
  assign srcs = {filtered_external_trigger_out, filtered_input_2_in, filtered_input_1_in,
                 input1_edge_detect_in, internal_trigger_in};
  // shadow of the control register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q <= 16'h0000;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == `TSLV_SMCR_OFS) begin
      if (avs_byteenable_in[0]) cfg_q[7:0] <= avs_writedata_in[7:0] & 8'hf7;
      if (avs_byteenable_in[1]) cfg_q[15:8] <= avs_writedata_in[15:8];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  trig_select_a: assert property (trigger_input_out == srcs[cfg_q[6:4]])
    else $error("wrong trigger source");
  int_clock_a: assert property (slave_mode_select == 3'h0 && !cfg_q[14] && counter_enable_in |=> count_tick_out)
    else $error("internal clock tick missing");
  reinit_pulse_a: assert property (slave_mode_select == 3'h4 && !cfg_q[7] && $rose(trigger_input_out) |=> ##1 counter_reinit_out)
    else $error("reinit missing");
  sync_delay_a: assert property (slave_mode_select == 3'h4 && cfg_q[7] && $rose(trigger_input_out)
    |=> ##1 !counter_reinit_out ##1 counter_reinit_out) else $error("delayed reinit wrong");
  trig_start_a: assert property (slave_mode_select == 3'h6 && !cfg_q[7] && $rose(trigger_input_out) |=> ##1 counter_start_out)
    else $error("start missing");
  ext1_tick_a: assert property (slave_mode_select == 3'h7 && !cfg_q[7] && !cfg_q[14] && counter_enable_in
    && $rose(trigger_input_out) |=> ##1 count_tick_out) else $error("ext clock tick missing");
  gated_stop_a: assert property ((slave_mode_select == 3'h5 && !cfg_q[14] && !trigger_input_out) [*3] |=> !count_tick_out)
    else $error("gated tick while low");
  enc_in2_a: assert property (slave_mode_select == 3'h1 && counter_enable_in && $rose(filtered_input_2_in)
    |=> count_tick_out && count_down_out == !$past(filtered_input_1_in)) else $error("encoder 1 wrong");
  enc_in1_a: assert property (slave_mode_select == 3'h2 && counter_enable_in && $rose(filtered_input_1_in)
    |=> count_tick_out && count_down_out == $past(filtered_input_2_in)) else $error("encoder 2 wrong");
endmodule // tslv_slave_ctrl_assertions
bind tslv_slave_ctrl tslv_slave_ctrl_assertions chk (
  .core_clk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_byteenable_in, .avs_waitrequest_out, .counter_enable_in, .internal_trigger_in,
  .input1_edge_detect_in, .filtered_input_1_in, .filtered_input_2_in, .count_tick_out,
  .count_down_out, .counter_reinit_out, .counter_start_out, .trigger_input_out,
  .filtered_external_trigger_out
);
`default_nettype wire

// File: verif/tslv_far_side.sv
// far side model: trigger sources, encoder inputs, dead-time enable
// assumes the bench calls its tasks from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module tslv_far_side (
  input  wire logic       clk_in,   // core clock
  output logic            dts_out,  // dead-time enable
  output logic            pin_out,  // external trigger pin
  output logic [3:0]      itr_out,  // internal triggers
  output logic            ed_out,   // input 1 edge detect
  output logic            fi1_out,  // filtered input 1
  output logic            fi2_out   // filtered input 2
);
  initial begin
    dts_out = 1'b1;  // dead-time rate equals core rate
    {pin_out, fi2_out, fi1_out, ed_out, itr_out} = 8'h00;
  end
  task automatic drive(input logic [7:0] v);
    @(posedge clk_in);
    {pin_out, fi2_out, fi1_out, ed_out, itr_out} <= v;
  endtask
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge clk_in);
      itr_out[0] <= 1'b1;
      repeat (w) @(posedge clk_in);
      itr_out[0] <= 1'b0;
      repeat (w) @(posedge clk_in);
    end
  endtask
  task automatic pin_pulse(input int w);
    @(posedge clk_in);
    pin_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    pin_out <= 1'b0;
  endtask
  // two cycles per level keeps the trigger at a quarter of the clock
  task automatic pin_edges(input int n);
    repeat (2 * n) begin
      @(posedge clk_in);
      pin_out <= !pin_out;
      @(posedge clk_in);
    end
  endtask
  // quadrature steps, input 1 leads when forward
  task automatic enc(input int n, input logic rev);
    repeat (n) begin
      @(posedge clk_in);
      if (fi1_out ^ fi2_out ^ rev) fi2_out <= !fi2_out;
      else fi1_out <= !fi1_out;
      @(posedge clk_in);
    end
  endtask
endmodule // tslv_far_side
`default_nettype wire

// File: verif/tslv_slave_ctrl_tb.sv
// self-checking bench of the slave mode controller
// assumes the far side model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "tslv_map.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tslv_slave_ctrl_tb;
  import tslv_pkg::*;
  logic        core_clk_in       = 1'b0;
  logic        sys_rst_in        = 1'b1;
  logic [5:0]  avs_address_in    = 6'h00;
  logic        avs_read_in       = 1'b0;
  logic        avs_write_in      = 1'b0;
  logic [31:0] avs_writedata_in  = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'h3;
  logic        counter_enable_in = 1'b0;
  logic [31:0] avs_readdata_out, q;
  logic        wait_r, dts, pin, ed, fi1, fi2, tick, down, reinit, start, trigger_input, filtered_external_trigger, seen_f;
  logic [3:0]  itr;
  int          checks, n_mismatch, cyc, n_tick, n_reinit, n_start, w;
  logic [31:0] trg_rows [12] = '{32'h0000_0101, 32'h0010_0201, 32'h0020_0401, 32'h0030_0801,
    32'h0040_1001, 32'h0050_2001, 32'h0060_4001, 32'h0070_8001, 32'h0000_fe00, 32'h0070_7f00,
    32'h8070_0001, 32'h8070_8000};
  // cfg, enable, pulses, width, ticks, reinits, starts
  int          mrows [5][7] = '{'{4, 1, 3, 2, -1, 3, 0}, '{'h84, 1, 3, 2, -1, 3, 0},
    '{5, 1, 1, 10, 10, 0, 0}, '{6, 0, 1, 2, 1, 0, 1}, '{7, 1, 3, 2, 3, 0, 0}};
  int          flt_n [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  int          flt_d [16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
  int          enc_exp [3] = '{4, 4, 8};
  tslv_slave_ctrl dut (.core_clk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out(wait_r),
    .dts_tick_in(dts), .external_trigger_pin_in(pin), .internal_trigger_in(itr),
    .input1_edge_detect_in(ed), .filtered_input_1_in(fi1), .filtered_input_2_in(fi2),
    .counter_enable_in, .count_tick_out(tick), .count_down_out(down), .counter_reinit_out(reinit),
    .counter_start_out(start), .trigger_input_out(trigger_input), .filtered_external_trigger_out(filtered_external_trigger));
  tslv_far_side far (.clk_in(core_clk_in), .dts_out(dts), .pin_out(pin), .itr_out(itr),
    .ed_out(ed), .fi1_out(fi1), .fi2_out(fi2));
  always #50 core_clk_in = ~core_clk_in;
  always @(negedge core_clk_in) begin
    n_tick   += int'(tick === 1'b1);
    n_reinit += int'(reinit === 1'b1);
    n_start  += int'(start === 1'b1);
    if (filtered_external_trigger === 1'b1) seen_f = 1'b1;
  end
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      $display("timeout");
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request stands until waitrequest is low at a rising edge; only the bench timeout ends a hang
  task automatic bus(input logic w_en, input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_write_in     <= w_en;
    avs_read_in      <= !w_en;
    do begin
      @(posedge core_clk_in);
    end while (wait_r !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask
  task automatic wcfg(input logic [15:0] d);
    bus(1'b1, `TSLV_SMCR_OFS, d);
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, `TSLV_SMCR_OFS, 16'h0);
    `CHK("cfg reset", 32'h0, q)
    wcfg(16'hffff);
    bus(1'b0, `TSLV_SMCR_OFS, 16'h0);
    `CHK("cfg rw", 32'h0000_fff7, q)
    wcfg(16'h0000);
    bus(1'b0, 6'h3c, 16'h0);
    `CHK("unmapped", 32'h0, q)
    $display("register test done");
    foreach (trg_rows[i]) begin
      wcfg(trg_rows[i][31:16]);
      far.drive(trg_rows[i][15:8]);
      repeat (3) @(posedge core_clk_in);
      `CHK("trigger", trg_rows[i][0], trigger_input)
    end
    wcfg(16'h0000);
    $display("trigger test done");
    far.drive(8'h00);
    counter_enable_in <= 1'b1;
    n_tick = 0;
    repeat (20) @(posedge core_clk_in);
    counter_enable_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    `CHK("int ticks", 20, n_tick)
    foreach (mrows[i]) begin
      wcfg(16'(mrows[i][0]));
      counter_enable_in <= mrows[i][1][0];
      {n_tick, n_reinit, n_start} = '0;
      far.pulse(mrows[i][2], mrows[i][3]);
      repeat (4) @(posedge core_clk_in);
      counter_enable_in <= 1'b0;
      if (mrows[i][4] >= 0) `CHK("ticks", mrows[i][4], n_tick)
      `CHK("reinits", mrows[i][5], n_reinit)
      `CHK("starts", mrows[i][6], n_start)
      wcfg(16'h0000);
    end
    $display("mode test done");
    foreach (enc_exp[i]) begin
      wcfg(16'(i + 1));
      counter_enable_in <= 1'b1;
      n_tick = 0;
      far.enc(8, 1'b0);
      repeat (3) @(posedge core_clk_in);
      counter_enable_in <= 1'b0;
      `CHK("enc ticks", enc_exp[i], n_tick)
      `CHK("enc up", 1'b0, down)
    end
    counter_enable_in <= 1'b1;
    far.enc(4, 1'b1);
    repeat (3) @(posedge core_clk_in);
    counter_enable_in <= 1'b0;
    `CHK("enc down", 1'b1, down)
    bus(1'b0, `TSLV_STAT_OFS, 16'h0);
    `CHK("status", 32'h0000_0008, q)
    wcfg(16'h0000);
    $display("encoder test done");
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    bus(1'b0, `TSLV_SMCR_OFS, 16'h0);
    `CHK("cfg reset again", 32'h0, q)
    for (int p = 0; p < 5; p++) begin
      wcfg(p < 4 ? 16'h4000 | 16'(p << 12) : 16'h4007);
      counter_enable_in <= 1'b1;
      n_tick = 0;
      far.pin_edges(8);
      repeat (4) @(posedge core_clk_in);
      counter_enable_in <= 1'b0;
      `CHK("ext ticks", p < 4 ? 8 >> p : 8, n_tick)
    end
    $display("external clock test done");
    for (int c = 0; c < 16; c++) begin
      wcfg(16'(c << 8));
      for (int a = 0; a < 2; a++) begin
        w = flt_d[c] * (flt_n[c] + (a == 1 ? 1 : -1));
        if (w == 0) continue;
        seen_f = 1'b0;
        far.pin_pulse(w);
        repeat (flt_d[c] * flt_n[c] + 40) @(posedge core_clk_in);
        `CHK("filter pass", a[0], seen_f)
      end
    end
    $display("filter test done");
    tally_and_finish();
  end
endmodule // tslv_slave_ctrl_tb
`default_nettype wire
